// ### hw/spm_ctrl.sv
// Purpose: subactive power-mode controller with APB registers
// Assumes: CPU gives a sleep pulse, its mask bit and a wake request
// Notes: reset pin and oscillator-stable come from outside, synchronised
// How it works
// - Subactive stops oscillator unless watchdog keeps it, gates analog clocks
// - Subactive left only by sleep instruction or reset pin
// - Masked or disabled interrupt keeps subactive
// - Reset pin low restarts oscillator, then reset
// - Subactive clock is watch clock over 2/4/8
// - Divider change applies at next sleep
// - Direct transition keeps program running
// - Direct transition can change frequency in-mode
// - Direct transition completion raises interrupt
// - Disabled interrupt turns sleep into sleep/watch
// - Masked direct attempt gives unwakeable sleep/watch
// - Request flag shows pending direct interrupt
// - Transition time: sleep, wait, exception states
// - Interrupt wake from watch with low-speed bit clear restarts oscillator, then wait
// - At least eight states after clock halt; wait code 101 gives 2 states
// - Wait length from wait-select bits
// - Wait-select code maps to state counts
module spm_ctrl #(
  parameter logic [15:0] WS_8K = 16'h2000, // Wait code 000
  parameter logic [15:0] WS_16K = 16'h4000 // Wait code 001
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sleep_exec_i,
  input wire logic cpu_int_mask_i,
  input wire logic wake_req_i,
  input wire logic wake_en_i,
  input wire logic wdt_osc_keep_i,
  input wire logic watch_tick_i,
  input wire logic external_reset_n_i,
  input wire logic osc_stable_i,
  output spm_pkg::spm_clk_t clk_o,
  output logic cpu_reset_o,
  output logic irq_o
);
  import spm_pkg::*;

  // Registers and state
  logic [7:0] system_control_one; // Standby, wait select, speed bits
  logic [7:0] system_control_two; // Direct, medium speed, divider
  logic interrupt_enable_two; // Direct-transition interrupt mask
  logic interrupt_request_two; // Sticky direct-transition flag
  spm_mode_t mode; // Current operating mode
  spm_mode_t next_mode;
  logic [1:0] sub_sel; // Divider in use, loaded at sleep
  logic no_wake; // Direct attempt made with CPU mask set
  logic pend_dt; // Direct transition finishing after wait
  logic from_reset; // Wait started by the reset pin
  logic next_set_flag;
  logic start_wait;
  logic wait_busy;
  logic wait_done;
  logic sub_tick;
  // Synchronisers for the outside pins
  logic res_m, res_s;
  logic osc_m, osc_s;

  // Decoded control bits
  logic standby_select, low_speed_on, timer_mode_select;
  logic medium_speed_on, direct_transition_on;
  logic [2:0] wait_sel;
  logic dt_ok; // Direct transition may proceed
  logic wake; // Enabled interrupt is requesting
  logic wr_en;
  logic rd_en;
  logic hit;

  assign standby_select = system_control_one[B_STANDBY];
  assign low_speed_on = system_control_one[B_LOW_SPEED];
  assign timer_mode_select = system_control_one[B_TIMER_MODE];
  assign wait_sel = system_control_one[B_WAIT_HI:B_WAIT_LO];
  assign medium_speed_on = system_control_two[B_MED_SPEED];
  assign direct_transition_on = system_control_two[B_DIRECT];
  // Masked CPU or disabled enable blocks every direct transition
  assign dt_ok = direct_transition_on && interrupt_enable_two
    && !cpu_int_mask_i;
  assign wake = wake_req_i && wake_en_i && !cpu_int_mask_i;

  // Two-flop synchronisers, first stage read only by the second
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      res_m <= 1'b0;
      res_s <= 1'b0;
      osc_m <= 1'b0;
      osc_s <= 1'b0;
    end else begin
      res_m <= external_reset_n_i;
      res_s <= res_m;
      osc_m <= osc_stable_i;
      osc_s <= osc_m;
    end
  end

  // APB decode, zero-wait access
  assign pready_o = 1'b1;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  always_comb begin
    hit = 1'b1;
    case (paddr_i)
      ADDR_SYSCTL1, ADDR_SYSCTL2, ADDR_IEN2, ADDR_IRQ2, ADDR_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Read data and error, captured in the setup cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i && !penable_i) begin
      pslverr_o <= !hit;
      prdata_o <= 32'h0000_0000;
      if (rd_en) begin
        case (paddr_i)
          ADDR_SYSCTL1: prdata_o <= {24'h000000, system_control_one};
          ADDR_SYSCTL2: prdata_o <= {24'h000000, system_control_two};
          ADDR_IEN2: prdata_o <= {31'h0, interrupt_enable_two};
          ADDR_IRQ2: prdata_o <= {31'h0, interrupt_request_two};
          ADDR_STATUS: prdata_o <= {25'h0, sub_sel, wait_busy, clk_o.sys_osc_run, mode};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register writes
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      system_control_one <= RST_SYSCTL1;
      system_control_two <= RST_SYSCTL2;
      interrupt_enable_two <= 1'b0;
    end else if (wr_en) begin
      case (paddr_i)
        ADDR_SYSCTL1: system_control_one <= pwdata_i[7:0];
        ADDR_SYSCTL2: system_control_two <= {4'h0, pwdata_i[3:0]};
        ADDR_IEN2: interrupt_enable_two <= pwdata_i[B_DT_IRQ];
        default: ;
      endcase
    end
  end

  // Sticky request flag: a new event wins over a write-one clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      interrupt_request_two <= 1'b0;
    end else if (next_set_flag) begin
      interrupt_request_two <= 1'b1;
    end else if (wr_en && paddr_i == ADDR_IRQ2 && pwdata_i[B_DT_IRQ]) begin
      interrupt_request_two <= 1'b0;
    end
  end

  // Level interrupt while the unmasked flag stands
  assign irq_o = interrupt_request_two && interrupt_enable_two;

  // Next-mode decision
  always_comb begin
    next_mode = mode;
    next_set_flag = 1'b0;
    start_wait = 1'b0;
    unique case (mode)
      MODE_ACTIVE: begin
        if (sleep_exec_i) begin
          if (dt_ok && low_speed_on) begin
            next_mode = MODE_SUBACT;
            next_set_flag = 1'b1;
          end else if (dt_ok) begin
            next_set_flag = 1'b1;
          end else if (standby_select) begin
            next_mode = MODE_WATCH;
          end else begin
            next_mode = MODE_SLEEP;
          end
        end
      end
      MODE_SUBACT: begin
        // Only the sleep instruction or the reset pin leaves subactive
        if (sleep_exec_i) begin
          if (dt_ok && !low_speed_on) begin
            next_mode = MODE_OSC;
          end else if (dt_ok) begin
            next_set_flag = 1'b1;
          end else if (standby_select || timer_mode_select) begin
            next_mode = MODE_WATCH;
          end else begin
            next_mode = MODE_SUBSLEEP;
          end
        end
      end
      MODE_SLEEP: begin
        if (wake && !no_wake) begin
          next_mode = MODE_ACTIVE;
        end
      end
      MODE_SUBSLEEP: begin
        if (wake && !no_wake) begin
          next_mode = MODE_SUBACT;
        end
      end
      MODE_WATCH: begin
        // Oscillator restarts when the interrupt is accepted with the low-speed bit clear
        if (wake && !no_wake) begin
          next_mode = low_speed_on ? MODE_SUBACT : MODE_OSC;
        end
      end
      MODE_OSC: begin
        if (osc_s) begin
          next_mode = MODE_WAIT;
          start_wait = 1'b1;
        end
      end
      MODE_WAIT: begin
        // Stabilisation plus selected wait, then resume
        if (wait_done) begin
          next_mode = MODE_ACTIVE;
          next_set_flag = pend_dt;
        end
      end
      MODE_RESET: begin
        // Leaves only once the pin is high and the oscillator is stable
        if (res_s && osc_s) begin
          next_mode = MODE_WAIT;
          start_wait = 1'b1;
        end
      end
    endcase
    if (!res_s) begin
      next_mode = MODE_RESET;
      next_set_flag = 1'b0;
      start_wait = 1'b0;
    end
  end

  // Mode register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= MODE_RESET;
    end else begin
      mode <= next_mode;
    end
  end

  // Bookkeeping of why a wait runs and whether wake is barred
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_dt <= 1'b0;
      from_reset <= 1'b1;
      no_wake <= 1'b0;
    end else if (!res_s) begin
      pend_dt <= 1'b0;
      from_reset <= 1'b1;
      no_wake <= 1'b0;
    end else begin
      if (mode == MODE_SUBACT && next_mode == MODE_OSC) begin
        pend_dt <= 1'b1;
      end else if (mode == MODE_WAIT && wait_done) begin
        pend_dt <= 1'b0;
        from_reset <= 1'b0;
      end
      // Direct attempt under CPU mask: no interrupt may wake
      if (sleep_exec_i && (mode == MODE_ACTIVE || mode == MODE_SUBACT)) begin
        no_wake <= direct_transition_on && cpu_int_mask_i;
      end
    end
  end

  // Divider takes the programmed value only at a sleep
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sub_sel <= DIV_BY8;
    end else if (sleep_exec_i) begin
      sub_sel <= system_control_two[B_DIV_HI:B_DIV_LO];
    end
  end

  spm_sub_div u_div (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .watch_tick_i(watch_tick_i),
    .sel_i(sub_sel),
    .tick_o(sub_tick)
  );

  spm_wait_cnt #(
    .WS_8K(WS_8K),
    .WS_16K(WS_16K)
  ) u_wait (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(start_wait),
    .code_i(wait_sel),
    .busy_o(wait_busy),
    .done_o(wait_done)
  );

  // Clock enables and oscillator control, registered
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_o <= '0;
      cpu_reset_o <= 1'b1;
    end else begin
      cpu_reset_o <= (mode == MODE_RESET) || (mode == MODE_WAIT && from_reset);
      clk_o.sys_osc_run <= wdt_osc_keep_i || mode == MODE_ACTIVE
        || mode == MODE_SLEEP || mode == MODE_OSC || mode == MODE_WAIT
        || mode == MODE_RESET;
      clk_o.cpu_clk_en <= (mode == MODE_ACTIVE)
        || (mode == MODE_SUBACT && sub_tick);
      clk_o.periph_clk_en <= mode == MODE_ACTIVE || mode == MODE_SLEEP
        || ((mode == MODE_SUBACT || mode == MODE_SUBSLEEP) && sub_tick);
      // Analog converter and pulse-width unit stop at low speed
      clk_o.anlg_clk_en <= mode == MODE_ACTIVE || mode == MODE_SLEEP;
    end
  end

  // Subactive without watchdog keep stops the oscillator
  chk_sub_osc_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mode == MODE_SUBACT && !wdt_osc_keep_i) |=> !clk_o.sys_osc_run)
    else $error("oscillator running in subactive");

  chk_sub_anlg_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mode == MODE_SUBACT) |=> !clk_o.anlg_clk_en)
    else $error("analog clock running in subactive");

  chk_sub_stay: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mode == MODE_SUBACT && !sleep_exec_i && res_s) |=> mode == MODE_SUBACT)
    else $error("subactive left without sleep");

  chk_mask_no_wake: assert property (@(posedge mclk_i) disable iff (rst_i)
    ((mode == MODE_SLEEP || mode == MODE_SUBSLEEP || mode == MODE_WATCH) && no_wake
    && res_s) |=> $stable(mode))
    else $error("masked sleep woken");

  chk_reset_osc_on: assert property (@(posedge mclk_i) disable iff (rst_i)
    !res_s |=> mode == MODE_RESET ##1 clk_o.sys_osc_run)
    else $error("reset pin did not start oscillator");

  chk_dt_flag_set: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mode == MODE_WAIT && wait_done && pend_dt && res_s) |=> interrupt_request_two)
    else $error("direct transition flag not raised");

  chk_div_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !sleep_exec_i |=> $stable(sub_sel))
    else $error("divider changed without sleep");

  chk_wait_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mode == MODE_WAIT) |=> !clk_o.cpu_clk_en)
    else $error("cpu clocked during wait");
endmodule : spm_ctrl

// ### hw/spm_pkg.sv
// Purpose: shared constants and types for the subactive power-mode controller
// Assumes: 32-bit APB register bus, one system clock
// Notes: wait-state counts above 4096 come from top-level parameters
package spm_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_SYSCTL1 = 8'h00;
  localparam logic [7:0] ADDR_SYSCTL2 = 8'h04;
  localparam logic [7:0] ADDR_IEN2 = 8'h08;
  localparam logic [7:0] ADDR_IRQ2 = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // System control one fields
  localparam int B_STANDBY = 7;
  localparam int B_WAIT_HI = 6;
  localparam int B_WAIT_LO = 4;
  localparam int B_LOW_SPEED = 3;
  localparam int B_TIMER_MODE = 2;
  // System control two fields
  localparam int B_DIRECT = 3;
  localparam int B_MED_SPEED = 2;
  localparam int B_DIV_HI = 1;
  localparam int B_DIV_LO = 0;
  // Interrupt enable / request bit
  localparam int B_DT_IRQ = 0;
  // Reset values
  localparam logic [7:0] RST_SYSCTL1 = 8'h00;
  localparam logic [7:0] RST_SYSCTL2 = 8'h00;
  // Wait-state table entries of 4096 or less
  localparam int unsigned WS_1K = 32'h0000_0400;
  localparam int unsigned WS_2K = 32'h0000_0800;
  localparam int unsigned WS_4K = 32'h0000_1000;
  localparam int unsigned WS_EXT = 32'h0000_0002;
  localparam int unsigned WS_8 = 32'h0000_0008;
  localparam int unsigned WS_16 = 32'h0000_0010;
  localparam logic [2:0] WCODE_EXT = 3'h5;
  // Watch-clock divider select codes
  localparam logic [1:0] DIV_BY8 = 2'h0;
  localparam logic [1:0] DIV_BY4 = 2'h1;
  localparam logic [2:0] DCNT_8 = 3'h7;
  localparam logic [2:0] DCNT_4 = 3'h3;
  localparam logic [2:0] DCNT_2 = 3'h1;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_ACTIVE, MODE_SUBACT, MODE_SLEEP, MODE_SUBSLEEP,
    MODE_WATCH, MODE_OSC, MODE_WAIT, MODE_RESET
  } spm_mode_t;
  // Clock and oscillator controls leaving the block
  typedef struct packed {
    logic sys_osc_run;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic anlg_clk_en;
  } spm_clk_t;

  // Wait-select code to number of system clock states
  function automatic logic [15:0] wait_states(input logic [2:0] code,
      input logic [15:0] ws8k, input logic [15:0] ws16k);
    logic [15:0] n;
    n = ws8k;
    case (code)
      3'h0: n = ws8k;
      3'h1: n = ws16k;
      3'h2: n = 16'(WS_1K);
      3'h3: n = 16'(WS_2K);
      3'h4: n = 16'(WS_4K);
      3'h5: n = 16'(WS_EXT);
      3'h6: n = 16'(WS_8);
      default: n = 16'(WS_16);
    endcase
    return n;
  endfunction : wait_states
endpackage : spm_pkg

// ### hw/spm_wait_cnt.sv
// Purpose: post-restart wait counter in system clock states
// Assumes: start_i is a one-cycle pulse, code_i stable while busy
// Notes: done_o pulses in the cycle after the count reaches its target
module spm_wait_cnt #(
  parameter logic [15:0] WS_8K = 16'h2000,
  parameter logic [15:0] WS_16K = 16'h4000
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [2:0] code_i,
  output logic busy_o,
  output logic done_o
);
  import spm_pkg::*;
  logic [15:0] cnt; // States counted so far
  logic [15:0] target; // Latched length of this wait

  // Count system clock states, release at the selected number
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 16'h0000;
      target <= 16'h0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        target <= wait_states(code_i, WS_8K, WS_16K);
        cnt <= 16'h0001;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt == target) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
    end
  end

  // Crystal codes never release sooner than eight states
  chk_wait_min_len: assert property (@(posedge mclk_i) disable iff (rst_i)
    (start_i && code_i != WCODE_EXT) |=> !done_o [*8])
    else $error("wait released too early");
endmodule : spm_wait_cnt

// ### hw/spm_sub_div.sv
// Purpose: divides the watch clock tick by 2, 4 or 8
// Assumes: watch_tick_i is a one-cycle enable in the system clock domain
// Notes: select is the latched copy, so it only changes at a sleep
module spm_sub_div (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic watch_tick_i,
  input wire logic [1:0] sel_i,
  output logic tick_o
);
  import spm_pkg::*;
  logic [2:0] cnt; // Watch ticks seen
  logic [2:0] last; // Terminal count for the selection

  // Decode select to terminal count
  always_comb begin
    last = DCNT_2;
    if (sel_i == DIV_BY8) begin
      last = DCNT_8;
    end else if (sel_i == DIV_BY4) begin
      last = DCNT_4;
    end
  end

  // Divide watch ticks into one subactive tick
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 3'h0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (watch_tick_i) begin
        if (cnt >= last) begin
          cnt <= 3'h0;
          tick_o <= 1'b1;
        end else begin
          cnt <= cnt + 3'h1;
        end
      end
    end
  end

  // A subactive tick never repeats back to back
  chk_div_tick_gap: assert property (@(posedge mclk_i) disable iff (rst_i)
    tick_o |=> !tick_o)
    else $error("subactive tick repeated");
endmodule : spm_sub_div

// ### tb/spm_far_side.sv
// Purpose: far-side model: oscillator, reset pin and watch tick
// Assumes: oscillator settles STAB+1 clocks after it is started
// Notes: reset pin is held low until the oscillator is stable
module spm_far_side #(
  parameter int STAB = 20, // Settling time in system clocks
  parameter int TICK_P = 4 // System clocks per watch tick
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic osc_run_i,
  input wire logic pin_req_i,
  output logic osc_stable_o,
  output logic external_reset_n_o,
  output logic watch_tick_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int stab_cnt; // Clocks since oscillator start
  int tick_cnt; // Watch tick prescaler
  // Stable only after settling; a halt drops it at once
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i || !osc_run_i) begin
      stab_cnt <= 0;
      osc_stable_o <= 1'b0;
    end else if (stab_cnt < STAB) begin
      stab_cnt <= stab_cnt + 1;
    end else begin
      osc_stable_o <= 1'b1;
    end
  end
  // Pin released only once clocks are clean, else the chip runs on junk
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      external_reset_n_o <= 1'b1;
    end else if (pin_req_i) begin
      external_reset_n_o <= 1'b0;
    end else if (osc_stable_o) begin
      external_reset_n_o <= 1'b1;
    end
  end
  // Free-running watch clock tick
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt <= 0;
    end else begin
      tick_cnt <= (tick_cnt == TICK_P - 1) ? 0 : tick_cnt + 1;
    end
  end
  assign watch_tick_o = (tick_cnt == TICK_P - 1);
endmodule : spm_far_side

// ### tb/spm_ctrl_bench.sv
// Purpose: self-checking bench for the subactive power-mode controller
// Assumes: APB slave answers at once; far-side model drives oscillator
// Notes: wait codes 000 and 001 are shortened through parameters
module spm_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import spm_pkg::*;
  localparam logic [15:0] W8K = 16'h0020; // Short count for code 000
  localparam logic [15:0] W16K = 16'h0040; // Short count for code 001
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sleep = 1'b0, mask = 1'b0, wreq = 1'b0, wen = 1'b0, pin_req = 1'b0;
  logic [31:0] prdata_o, q;
  logic pready_o, pslverr_o, cpu_reset_o, irq_o, osc_ok, pin_n, tick, e;
  spm_clk_t clk_o;
  int err_count = 0;
  int check_count = 0;
  int n;
  int wt [8] = '{int'(W8K), int'(W16K), 1024, 2048, 4096, 2, 8, 16}; // States per code
  // 10 MHz system clock
  always #50 mclk_i = ~mclk_i;
  spm_ctrl #(.WS_8K(W8K), .WS_16K(W16K)) i_dut (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .sleep_exec_i(sleep),
    .cpu_int_mask_i(mask),
    .wake_req_i(wreq),
    .wake_en_i(wen),
    .wdt_osc_keep_i(1'b0),
    .watch_tick_i(tick),
    .external_reset_n_i(pin_n),
    .osc_stable_i(osc_ok),
    .clk_o(clk_o),
    .cpu_reset_o(cpu_reset_o),
    .irq_o(irq_o)
  );
  spm_far_side i_far (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .osc_run_i(clk_o.sys_osc_run),
    .pin_req_i(pin_req),
    .osc_stable_o(osc_ok),
    .external_reset_n_o(pin_n),
    .watch_tick_o(tick)
  );
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : check
  // Single place the run ends
  task wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  task hang(input string what);
    err_count++;
    $display("ERROR t=%0t timeout %s", $time, what);
    wrap_up();
  endtask : hang
  // One APB transfer; ends at a falling edge so effects have landed
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_i);
      q = prdata_o;
      e = pslverr_o;
      k++;
    end while (pready_o !== 1'b1 && k < 16);
    if (k >= 16) hang("apb");
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge mclk_i);
  endtask : apb
  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string w);
    apb(1'b0, a, 32'h0);
    check(q & m, x, w);
  endtask : rdc
  task mode_is(input spm_mode_t md);
    rdc(ADDR_STATUS, 32'h7, 32'(md), "mode");
  endtask : mode_is
  // Wait code, low-speed bit, divider; direct transition always on
  task cfg(input logic [2:0] code, input logic ls, input logic [1:0] dv);
    apb(1'b1, ADDR_SYSCTL1, 32'({code, ls, 3'h0}));
    apb(1'b1, ADDR_SYSCTL2, 32'({2'h2, dv}));
  endtask : cfg
  task do_sleep();
    @(posedge mclk_i);
    sleep <= 1'b1;
    @(posedge mclk_i);
    sleep <= 1'b0;
    @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : do_sleep
  // Count CPU clock enables over a window
  task pulses(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge mclk_i);
      if (clk_o.cpu_clk_en === 1'b1) n++;
    end
  endtask : pulses
  task wait_active();
    int k;
    k = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end while (q[2:0] !== MODE_ACTIVE && k < 200);
    if (k >= 200) hang("active");
  endtask : wait_active
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    wait_active();
    check(32'(cpu_reset_o), 32'h0, "cpu out of reset");
    check(32'(clk_o), 32'hf, "active clocks");
    rdc(ADDR_SYSCTL1, 32'hff, 32'(RST_SYSCTL1), "ctl1 reset");
    rdc(ADDR_SYSCTL2, 32'hff, 32'(RST_SYSCTL2), "ctl2 reset");
    apb(1'b0, 8'h20, 32'h0);
    check({q[30:0], e}, 32'h1, "unmapped read");
    // Direct entry into subactive raises the request
    apb(1'b1, ADDR_IEN2, 32'h1);
    cfg(3'h6, 1'b1, DIV_BY8);
    do_sleep();
    mode_is(MODE_SUBACT);
    check(32'(irq_o), 32'h1, "irq after direct");
    rdc(ADDR_IRQ2, 32'h1, 32'h1, "request flag");
    check(32'({clk_o.sys_osc_run, clk_o.anlg_clk_en}), 32'h0, "sub clocks");
    apb(1'b1, ADDR_IEN2, 32'h0);
    check(32'(irq_o), 32'h0, "irq masked");
    apb(1'b1, ADDR_IEN2, 32'h1);
    apb(1'b1, ADDR_IRQ2, 32'h1);
    check(32'(irq_o), 32'h0, "flag cleared");
    pulses(256);
    check(32'(n >= 7 && n <= 9), 32'h1, "rate over 8");
    // New divider waits for the next sleep
    cfg(3'h6, 1'b1, 2'h2);
    pulses(256);
    check(32'(n >= 7 && n <= 9), 32'h1, "rate held");
    do_sleep();
    mode_is(MODE_SUBACT);
    check(32'(irq_o), 32'h1, "irq in-mode");
    apb(1'b1, ADDR_IRQ2, 32'h1);
    pulses(256);
    check(32'(n >= 31 && n <= 33), 32'h1, "rate over 2");
    @(posedge mclk_i);
    wen <= 1'b1;
    wreq <= 1'b1;
    repeat (6) @(posedge mclk_i);
    wreq <= 1'b0;
    mode_is(MODE_SUBACT);
    // Masked direct attempt: sleep that no interrupt ends
    @(posedge mclk_i);
    mask <= 1'b1;
    do_sleep();
    mode_is(MODE_SUBSLEEP);
    @(posedge mclk_i);
    mask <= 1'b0;
    wreq <= 1'b1;
    repeat (8) @(posedge mclk_i);
    wreq <= 1'b0;
    mode_is(MODE_SUBSLEEP);
    // Reset pin restarts the oscillator
    @(posedge mclk_i);
    pin_req <= 1'b1;
    repeat (6) @(posedge mclk_i);
    pin_req <= 1'b0;
    check(32'({clk_o.sys_osc_run, cpu_reset_o}), 32'h3, "pin reset");
    mode_is(MODE_RESET);
    wait_active();
    // Disabled request turns the sleep into plain sleep
    apb(1'b1, ADDR_IEN2, 32'h0);
    cfg(3'h6, 1'b0, DIV_BY8);
    do_sleep();
    mode_is(MODE_SLEEP);
    // CPU mask holds off the wake until it clears
    @(posedge mclk_i);
    mask <= 1'b1;
    wreq <= 1'b1;
    repeat (4) @(posedge mclk_i);
    mode_is(MODE_SLEEP);
    @(posedge mclk_i);
    mask <= 1'b0;
    repeat (4) @(posedge mclk_i);
    wreq <= 1'b0;
    mode_is(MODE_ACTIVE);
    // Standby bit with the request disabled gives watch mode
    apb(1'b1, ADDR_SYSCTL1, 32'h0000_00e0);
    do_sleep();
    mode_is(MODE_WATCH);
    check(32'(clk_o.sys_osc_run), 32'h0, "osc off in watch");
    @(posedge mclk_i);
    wreq <= 1'b1;
    repeat (4) @(posedge mclk_i);
    wreq <= 1'b0;
    check(32'(clk_o.sys_osc_run), 32'h1, "osc on wake");
    wait_active();
    apb(1'b1, ADDR_IEN2, 32'h1);
    do_sleep();
    mode_is(MODE_ACTIVE);
    check(32'(irq_o), 32'h1, "irq active");
    apb(1'b1, ADDR_IRQ2, 32'h1);
    // Every wait code on the way back to active
    for (int c = 0; c < 8; c++) begin
      cfg(3'(c), 1'b1, DIV_BY8);
      do_sleep();
      apb(1'b1, ADDR_IRQ2, 32'h1);
      cfg(3'(c), 1'b0, DIV_BY8);
      do_sleep();
      check(32'(clk_o.sys_osc_run), 32'h1, "osc restart");
      n = 0;
      while (osc_ok !== 1'b1 && n < 100) begin
        @(posedge mclk_i);
        n++;
      end
      if (n >= 100) hang("osc");
      n = 0;
      while (clk_o.cpu_clk_en !== 1'b1 && n < 20000) begin
        @(posedge mclk_i);
        n++;
      end
      check(32'(n >= wt[c] && n <= wt[c] + 6), 32'h1, "wait length");
      mode_is(MODE_ACTIVE);
      check(32'(irq_o), 32'h1, "irq at wait end");
      apb(1'b1, ADDR_IRQ2, 32'h1);
    end
    wrap_up();
  end
endmodule : spm_ctrl_bench
